// ===== pkg/dma_status_map.svh
// Register addresses, field positions, reset values and code points of the DMA status block
`ifndef DMA_STATUS_MAP_SVH
`define DMA_STATUS_MAP_SVH

// ----------------------------------------------------------------------------
// Register page and byte addresses
// ----------------------------------------------------------------------------
`define DMA_REG_PAGE       4'hF
`define DMA_MID_ADDR       8'h88
`define DMA_EN_ADDR        8'h92
`define DMA_FULL_ADDR      8'hE8
`define DMA_BUSY_ADDR      8'h91

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define DMA_NUM_CHAN       7
`define DMA_CHAN_MSB       6
`define DMA_RSVD_BIT       7
`define DMA_REG_RESET      8'h00
`define DMA_BITS_RESET     7'h00
`define DMA_OFFSET_RESET   10'h000
`define DMA_ADDR_RESET     12'h000
`define DMA_SEL_RESERVED   3'h7

`endif

// ===== pkg/dma_status_pkg.sv
// Types shared by the DMA channel status register files
package dma_status_pkg;

  typedef logic [7:0]  sfr_byte_t;
  typedef logic [6:0]  chan_bits_t;
  typedef logic [9:0]  offset_t;
  typedef logic [11:0] xram_addr_t;
  typedef logic [2:0]  chan_sel_t;

endpackage : dma_status_pkg

// ===== rtl/chan_flag_unit.sv
// One DMA channel: offset counter, full and mid flags, busy bit and request gating
`timescale 1ns/100ps
`include "dma_status_map.svh"

module chan_flag_unit (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  input  wire logic                       enable,
  input  wire logic                       stall,
  input  wire dma_status_pkg::offset_t    size,
  input  wire dma_status_pkg::xram_addr_t base,
  input  wire logic                       offset_wr,
  input  wire dma_status_pkg::offset_t    offset_wdata,
  input  wire logic                       byte_done,
  input  wire logic                       xfer_active,
  input  wire logic                       full_wr,
  input  wire logic                       full_wval,
  input  wire logic                       mid_wr,
  input  wire logic                       mid_wval,
  input  wire logic                       busy_wr,
  input  wire logic                       busy_wval,
  output logic                            full_q,
  output logic                            mid_q,
  output logic                            busy_q,
  output logic                            ready_q,
  output logic                            start_q,
  output dma_status_pkg::offset_t         offset_q,
  output dma_status_pkg::xram_addr_t      addr_q
);

  logic                       full_d;
  logic                       mid_d;
  logic                       busy_d;
  logic                       ready_d;
  logic                       start_d;
  logic                       active_q;
  logic                       active_d;
  logic                       force_go;
  dma_status_pkg::offset_t    offset_d;
  dma_status_pkg::offset_t    full_target;
  dma_status_pkg::offset_t    mid_target;
  dma_status_pkg::xram_addr_t addr_d;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    full_target = size - 10'h001;
    mid_target  = {1'b0, size[9:1]};
    if (size[0]) begin
      mid_target = {1'b0, size[9:1]} + 10'h001;
    end
    force_go = busy_wr & busy_wval & enable & ~stall;
    start_d  = force_go;
    offset_d = offset_q;
    // Software loads are locked out while the channel moves data
    if (offset_wr && !busy_q) begin
      offset_d = offset_wdata;
    end else if (byte_done) begin
      offset_d = offset_q + 10'h001;
    end
    addr_d = base + {2'b00, offset_d};
    full_d = full_wr ? full_wval : full_q;
    if (byte_done && (offset_q == full_target)) begin
      full_d = 1'b1;
    end
    mid_d = mid_wr ? mid_wval : mid_q;
    if (byte_done && (offset_q == mid_target)) begin
      mid_d = 1'b1;
    end
    active_d = xfer_active;
    busy_d = xfer_active | force_go | (busy_q & ~(active_q & ~xfer_active));
    ready_d = enable & ((~stall & ~full_q) | xfer_active);
  end

  // --------------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full_q   <= 1'b0;
      mid_q    <= 1'b0;
      busy_q   <= 1'b0;
      ready_q  <= 1'b0;
      start_q  <= 1'b0;
      active_q <= 1'b0;
      offset_q <= `DMA_OFFSET_RESET;
      addr_q   <= `DMA_ADDR_RESET;
    end else if (ce) begin
      full_q   <= full_d;
      mid_q    <= mid_d;
      busy_q   <= busy_d;
      ready_q  <= ready_d;
      start_q  <= start_d;
      active_q <= active_d;
      offset_q <= offset_d;
      addr_q   <= addr_d;
    end
  end

endmodule : chan_flag_unit

// ===== rtl/dma_channel_status_regs.sv
// Enable, interrupt-flag and busy register set of a seven-channel DMA engine
//
// How it works
// - Bits 0..6 of the enable register enable channels 0..6.
// - Full-length flag register holds one flag per channel, bits 0..6.
// - Full flag sets when the byte at offset size minus one moves.
// - Full flag stays until software writes it to zero.
// - Full condition interrupts only with that channel's full enable set.
// - Mid-point flag register holds one flag per channel, bits 0..6.
// - Even size: mid flag sets when offset equals half the size.
// - Odd size: mid flag sets when offset equals half plus one.
// - Mid flag stays until software writes it to zero.
// - Mid condition interrupts only with that channel's mid enable set.
// - Full flags are bit addressable on page F.
// - Mid flags are bit addressable on page F.
// - Busy set while transferring; writing one forces a transfer start on an enabled, unstalled channel.
// - Three-bit select picks channels 0..6; code 7 selects nothing.
// - Offset counter increments per byte; address is base plus offset.
// - Stall lets running transfer finish, blocks new ones.
`timescale 1ns/100ps
`include "dma_status_map.svh"

module dma_channel_status_regs (
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 ce,
  input  wire logic [3:0]                           sfr_page,
  input  wire logic [7:0]                           sfr_addr,
  input  wire logic                                 sfr_wr,
  input  wire logic                                 sfr_rd,
  input  wire dma_status_pkg::sfr_byte_t            sfr_wdata,
  input  wire logic                                 bit_wr,
  input  wire logic [7:0]                           bit_addr,
  input  wire logic                                 bit_wdata,
  input  wire dma_status_pkg::chan_sel_t            chan_select,
  input  wire logic                                 offset_wr,
  input  wire dma_status_pkg::offset_t              offset_wdata,
  input  wire logic [6:0][9:0]                      transfer_size,
  input  wire logic [6:0][11:0]                     xram_base,
  input  wire dma_status_pkg::chan_bits_t           full_irq_enable,
  input  wire dma_status_pkg::chan_bits_t           mid_irq_enable,
  input  wire dma_status_pkg::chan_bits_t           stall,
  input  wire dma_status_pkg::chan_bits_t           byte_done,
  input  wire dma_status_pkg::chan_bits_t           xfer_active,
  output dma_status_pkg::sfr_byte_t                 sfr_rdata,
  output logic                                      irq,
  output dma_status_pkg::chan_bits_t                channel_enables,
  output dma_status_pkg::chan_bits_t                full_length_flags,
  output dma_status_pkg::chan_bits_t                midpoint_flags,
  output dma_status_pkg::chan_bits_t                channel_busy,
  output dma_status_pkg::chan_bits_t                chan_ready,
  output dma_status_pkg::chan_bits_t                force_start,
  output logic [6:0][9:0]                           byte_offset_counter,
  output logic [6:0][11:0]                          xram_addr
);

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  logic                       page_hit;
  logic                       wr_en_reg;
  logic                       wr_full_byte;
  logic                       wr_mid_byte;
  logic                       wr_busy_byte;
  dma_status_pkg::chan_bits_t full_wr;
  dma_status_pkg::chan_bits_t full_wval;
  dma_status_pkg::chan_bits_t mid_wr;
  dma_status_pkg::chan_bits_t mid_wval;
  dma_status_pkg::chan_bits_t busy_wval;
  dma_status_pkg::chan_bits_t offset_sel;

  always_comb begin
    page_hit     = (sfr_page == `DMA_REG_PAGE);
    wr_en_reg    = page_hit & sfr_wr & (sfr_addr == `DMA_EN_ADDR);
    wr_full_byte = page_hit & sfr_wr & (sfr_addr == `DMA_FULL_ADDR);
    wr_mid_byte  = page_hit & sfr_wr & (sfr_addr == `DMA_MID_ADDR);
    wr_busy_byte = page_hit & sfr_wr & (sfr_addr == `DMA_BUSY_ADDR);
    full_wr      = `DMA_BITS_RESET;
    full_wval    = `DMA_BITS_RESET;
    mid_wr       = `DMA_BITS_RESET;
    mid_wval     = `DMA_BITS_RESET;
    busy_wval    = sfr_wdata[`DMA_CHAN_MSB:0];
    offset_sel   = `DMA_BITS_RESET;
    for (int n = 0; n < `DMA_NUM_CHAN; n++) begin
      if (wr_full_byte) begin
        full_wr[n]   = 1'b1;
        full_wval[n] = sfr_wdata[n];
      end else if (page_hit && bit_wr && (bit_addr == (`DMA_FULL_ADDR + 8'(n)))) begin
        full_wr[n]   = 1'b1;
        full_wval[n] = bit_wdata;
      end
      if (wr_mid_byte) begin
        mid_wr[n]   = 1'b1;
        mid_wval[n] = sfr_wdata[n];
      end else if (page_hit && bit_wr && (bit_addr == (`DMA_MID_ADDR + 8'(n)))) begin
        mid_wr[n]   = 1'b1;
        mid_wval[n] = bit_wdata;
      end
      if (offset_wr && (chan_select != `DMA_SEL_RESERVED) && (chan_select == 3'(n))) begin
        offset_sel[n] = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Channels
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < `DMA_NUM_CHAN; g++) begin : g_chan
    chan_flag_unit u_chan (
      .clk          (clk),
      .rst_n        (rst_n),
      .ce           (ce),
      .enable       (channel_enables[g]),
      .stall        (stall[g]),
      .size         (transfer_size[g]),
      .base         (xram_base[g]),
      .offset_wr    (offset_sel[g]),
      .offset_wdata (offset_wdata),
      .byte_done    (byte_done[g]),
      .xfer_active  (xfer_active[g]),
      .full_wr      (full_wr[g]),
      .full_wval    (full_wval[g]),
      .mid_wr       (mid_wr[g]),
      .mid_wval     (mid_wval[g]),
      .busy_wr      (wr_busy_byte),
      .busy_wval    (busy_wval[g]),
      .full_q       (full_length_flags[g]),
      .mid_q        (midpoint_flags[g]),
      .busy_q       (channel_busy[g]),
      .ready_q      (chan_ready[g]),
      .start_q      (force_start[g]),
      .offset_q     (byte_offset_counter[g]),
      .addr_q       (xram_addr[g])
    );
  end

  // --------------------------------------------------------------------------
  // Enable register
  // --------------------------------------------------------------------------
  dma_status_pkg::chan_bits_t en_q;
  dma_status_pkg::chan_bits_t en_d;

  assign channel_enables = en_q;

  always_comb begin
    en_d = en_q;
    if (wr_en_reg) begin
      // Reserved bit 7 is dropped so a careless write cannot stick
      en_d = sfr_wdata[`DMA_CHAN_MSB:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= `DMA_BITS_RESET;
    end else if (ce) begin
      en_q <= en_d;
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  dma_status_pkg::sfr_byte_t rdata_q;
  dma_status_pkg::sfr_byte_t rdata_d;

  assign sfr_rdata = rdata_q;

  // Unmapped or wrong-page reads return zero rather than stale data
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd) begin
      rdata_d = `DMA_REG_RESET;
      if (page_hit) begin
        case (sfr_addr)
          `DMA_EN_ADDR:   rdata_d = {1'b0, en_q};
          `DMA_FULL_ADDR: rdata_d = {1'b0, full_length_flags};
          `DMA_MID_ADDR:  rdata_d = {1'b0, midpoint_flags};
          `DMA_BUSY_ADDR: rdata_d = {1'b0, channel_busy};
          default:        rdata_d = `DMA_REG_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `DMA_REG_RESET;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt request
  // --------------------------------------------------------------------------
  dma_status_pkg::chan_bits_t full_req;
  dma_status_pkg::chan_bits_t mid_req;
  logic                       irq_q;
  logic                       irq_d;

  assign irq = irq_q;

  // Level request: drops only once firmware clears the flag or its enable
  always_comb begin
    full_req = full_length_flags & full_irq_enable;
    mid_req  = midpoint_flags & mid_irq_enable;
    irq_d    = (|full_req) | (|mid_req);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= irq_d;
    end
  end

endmodule : dma_channel_status_regs

// ===== testbench/cpu_sfr_model.sv
// Firmware model: byte reads, byte writes and single-bit writes on page-addressed registers
`timescale 1ns/100ps

module cpu_sfr_model (
  input  wire logic       clk,
  input  wire logic [7:0] sfr_rdata,
  output logic [3:0]      sfr_page,
  output logic [7:0]      sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic [7:0]      sfr_wdata,
  output logic            bit_wr,
  output logic [7:0]      bit_addr,
  output logic            bit_wdata
);
  initial begin
    {sfr_page, sfr_addr, sfr_wr, sfr_rd, sfr_wdata, bit_wr, bit_addr, bit_wdata} = '0;
  end

  // ----------------------------------------
  // Access task, kind 1 write, 2 read, 3 bit
  // ----------------------------------------
  task automatic access(input logic [1:0] k, input logic [3:0] pg, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    sfr_page  <= pg;
    sfr_addr  <= a;
    bit_addr  <= a;
    sfr_wdata <= {1'h0, d[6:0]};
    bit_wdata <= d[0];
    sfr_wr    <= (k == 2'h1);
    sfr_rd    <= (k == 2'h2);
    bit_wr    <= (k == 2'h3);
    @(posedge clk);
    {sfr_wr, sfr_rd, bit_wr} <= 3'h0;
    // Released lines scramble so stale values are never trusted
    sfr_addr  <= ~a;
    bit_addr  <= ~a;
    sfr_wdata <= ~d;
    #1;
    q = sfr_rdata;
  endtask : access
endmodule : cpu_sfr_model

// ===== testbench/dma_status_monitor.sv
// Assertion checker for the DMA status register set
`timescale 1ns/100ps
`include "dma_status_map.svh"

module dma_status_monitor (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             ce,
  input wire logic [3:0]       sfr_page,
  input wire logic [7:0]       sfr_addr,
  input wire logic             sfr_wr,
  input wire logic             bit_wr,
  input wire logic [7:0]       sfr_wdata,
  input wire logic [6:0][9:0]  transfer_size,
  input wire logic [6:0][9:0]  byte_offset_counter,
  input wire logic [6:0]       full_irq_enable,
  input wire logic [6:0]       mid_irq_enable,
  input wire logic [6:0]       stall,
  input wire logic [6:0]       byte_done,
  input wire logic [6:0]       xfer_active,
  input wire logic             irq,
  input wire logic [6:0]       channel_enables,
  input wire logic [6:0]       full_length_flags,
  input wire logic [6:0]       midpoint_flags,
  input wire logic [6:0]       chan_ready,
  input wire logic [6:0]       force_start
);
  logic [6:0] full_hit;
  logic [6:0] mid_hit;
  logic [6:0] force_req;
  logic       irq_cause;

  // Odd sizes take the floor half plus one
  always_comb begin
    for (int n = 0; n < 7; n++) begin
      full_hit[n] = ce & byte_done[n] & (byte_offset_counter[n] == transfer_size[n] - 10'h001);
      mid_hit[n]  = ce & byte_done[n] &
                    (byte_offset_counter[n] == (transfer_size[n] >> 1) + transfer_size[n][0]);
    end
    force_req = sfr_wdata[6:0] & channel_enables & ~stall;
    irq_cause = |((full_length_flags & full_irq_enable) | (midpoint_flags & mid_irq_enable));
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr(a);
    ce && sfr_wr && sfr_page == `DMA_REG_PAGE && sfr_addr == a;
  endsequence
  sequence s_quiet;
    ce && !sfr_wr && !bit_wr;
  endsequence

  property p_en_wr;
    s_wr(`DMA_EN_ADDR) |=> {1'h0, channel_enables} == ($past(sfr_wdata) & 8'h7F);
  endproperty
  property p_full_set;
    (|full_hit) |=> (full_length_flags & $past(full_hit)) == $past(full_hit);
  endproperty
  property p_mid_set;
    (|mid_hit) |=> (midpoint_flags & $past(mid_hit)) == $past(mid_hit);
  endproperty
  property p_full_hold;
    s_quiet |=> ($past(full_length_flags) & ~full_length_flags) == 7'h00;
  endproperty
  property p_mid_hold;
    s_quiet |=> ($past(midpoint_flags) & ~midpoint_flags) == 7'h00;
  endproperty
  property p_irq;
    ce |=> irq == $past(irq_cause);
  endproperty
  property p_force;
    s_wr(`DMA_BUSY_ADDR) |=> (force_start & $past(force_req)) == $past(force_req);
  endproperty
  property p_stall;
    $past(ce) |->
      (chan_ready & stall & ~xfer_active & $past(stall) & ~$past(xfer_active)) == 7'h00;
  endproperty

  a_en_wr:     assert property (p_en_wr) else $error("enable write lost");
  a_full_set:  assert property (p_full_set) else $error("full flag missed");
  a_mid_set:   assert property (p_mid_set) else $error("mid flag missed");
  a_full_hold: assert property (p_full_hold) else $error("full flag dropped");
  a_mid_hold:  assert property (p_mid_hold) else $error("mid flag dropped");
  a_irq:       assert property (p_irq) else $error("irq wrong");
  a_force:     assert property (p_force) else $error("forced start missed");
  a_stall:     assert property (p_stall) else $error("stalled channel ready");
endmodule : dma_status_monitor

bind dma_channel_status_regs dma_status_monitor dma_status_monitor_i (.clk, .rst_n, .ce,
  .sfr_page, .sfr_addr, .sfr_wr, .bit_wr, .sfr_wdata, .transfer_size, .byte_offset_counter,
  .full_irq_enable, .mid_irq_enable, .stall, .byte_done, .xfer_active, .irq, .channel_enables,
  .full_length_flags, .midpoint_flags, .chan_ready, .force_start);

// ===== testbench/dma_channel_status_regs_tb.sv
// Self-checking bench for the DMA status register set
`timescale 1ns/100ps
`include "dma_status_map.svh"

module dma_channel_status_regs_tb;
  logic             clk = 1'h0;
  logic             rst_n = 1'h0;
  logic             ce = 1'h1;
  logic             offset_wr = 1'h0;
  logic [2:0]       chan_select = 3'h0;
  logic [9:0]       offset_wdata = 10'h000;
  logic [6:0][9:0]  transfer_size = '0;
  logic [6:0][11:0] xram_base = '0;
  logic [6:0]       full_irq_enable = 7'h00, mid_irq_enable = 7'h00, stall = 7'h00;
  logic [6:0]       byte_done = 7'h00, xfer_active = 7'h00;
  wire  [7:0]       sfr_addr, sfr_wdata, bit_addr, sfr_rdata;
  wire  [3:0]       sfr_page;
  wire              sfr_wr, sfr_rd, bit_wr, bit_wdata, irq;
  wire  [6:0]       channel_enables, full_length_flags, midpoint_flags, channel_busy;
  wire  [6:0]       chan_ready, force_start;
  wire  [6:0][9:0]  byte_offset_counter;
  wire  [6:0][11:0] xram_addr;
  int               err_total = 0, n_tests = 0, cyc = 0, seed = 73685;
  logic [7:0]       v, rd;
  logic [9:0]       sz;
  logic [11:0]      base;
  logic [7:0]       regs [4] = '{`DMA_EN_ADDR, `DMA_FULL_ADDR, `DMA_MID_ADDR, `DMA_BUSY_ADDR};

  dma_channel_status_regs dma_channel_status_regs_i (.clk, .rst_n, .ce, .sfr_page,
    .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .bit_wr, .bit_addr, .bit_wdata, .chan_select,
    .offset_wr, .offset_wdata, .transfer_size, .xram_base, .full_irq_enable, .mid_irq_enable,
    .stall, .byte_done, .xfer_active, .sfr_rdata, .irq, .channel_enables, .full_length_flags,
    .midpoint_flags, .channel_busy, .chan_ready, .force_start, .byte_offset_counter, .xram_addr);
  cpu_sfr_model cpu_sfr_model_i (.clk, .sfr_rdata, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .bit_wr, .bit_addr, .bit_wdata);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic acc(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d);
    cpu_sfr_model_i.access(k, 4'hF, a, d, rd);
  endtask : acc

  function automatic logic [9:0] mid_of(input logic [9:0] s);
    return (s >> 1) + {9'h000, s[0]};
  endfunction : mid_of

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  always #25 clk = ~clk;

  // Hang guard, far above the fewer than two hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    foreach (regs[i]) begin
      acc(2'h2, regs[i], 8'h00);
      check(rd, 8'h00);
    end
    v = 8'($random(seed));
    cpu_sfr_model_i.access(2'h1, 4'h3, `DMA_EN_ADDR, 8'h7F, rd);
    acc(2'h2, `DMA_EN_ADDR, 8'h00);
    check(rd, 8'h00);
    acc(2'h1, `DMA_EN_ADDR, v);
    acc(2'h2, `DMA_EN_ADDR, 8'h00);
    check(rd, {1'h0, v[6:0]});
    acc(2'h2, 8'h90, 8'h00);
    check(rd, 8'h00);
    $display("register test done");
    acc(2'h1, `DMA_EN_ADDR, 8'h7F);
    for (int c = 0; c < 7; c++) begin
      // First two channels pin the even and odd half-size corners
      sz = (c == 0) ? 10'h004 : (c == 1) ? 10'h005 : 10'h002 + 10'($unsigned($random(seed)) % 9);
      base = 12'($random(seed));
      v = 8'($random(seed));
      @(posedge clk);
      transfer_size[c] <= sz;
      xram_base[c] <= base;
      full_irq_enable <= v[6:0];
      mid_irq_enable <= v[7:1];
      chan_select <= 3'(c);
      offset_wr <= 1'h1;
      @(posedge clk);
      offset_wr <= 1'h0;
      byte_done[c] <= 1'h1;
      for (int o = 0; o < sz; o++) begin
        @(posedge clk);
        if (o == sz - 1) byte_done[c] <= 1'h0;
        #1;
        check(midpoint_flags[c], o >= mid_of(sz));
        check(full_length_flags[c], o == sz - 1);
        check(byte_offset_counter[c], 12'(o + 1));
        check(xram_addr[c], 12'(base + o + 1));
      end
      @(posedge clk);
      #1;
      check(irq, v[c] | v[c+1]);
      check({full_length_flags[c], midpoint_flags[c]}, 2'h3);
      acc(2'h3, `DMA_FULL_ADDR + 8'(c), 8'h00);
      check({full_length_flags[c], midpoint_flags[c]}, 2'h1);
      acc(2'h3, `DMA_MID_ADDR + 8'(c), 8'h00);
      check(full_length_flags | midpoint_flags, 7'h00);
      @(posedge clk);
      #1;
      check(irq, 1'h0);
    end
    $display("transfer test done");
    @(posedge clk);
    offset_wdata <= 10'h155;
    chan_select <= 3'h0;
    offset_wr <= 1'h1;
    @(posedge clk);
    // Reserved select code must leave every counter alone
    offset_wdata <= 10'h0AA;
    chan_select <= `DMA_SEL_RESERVED;
    @(posedge clk);
    offset_wr <= 1'h0;
    #1;
    check(byte_offset_counter[0], 12'h155);
    for (int c = 1; c < 7; c++) begin
      check(byte_offset_counter[c] == 10'h0AA, 1'h0);
    end
    $display("select test done");
    @(posedge clk);
    stall <= 7'h55;
    acc(2'h1, `DMA_EN_ADDR, 8'h1F);
    acc(2'h1, `DMA_BUSY_ADDR, 8'h7F);
    check(force_start, 7'h0A);
    @(posedge clk);
    xfer_active <= 7'h0A;
    stall <= 7'h7F;
    repeat (2) @(posedge clk);
    #1;
    check(chan_ready, 7'h0A);
    acc(2'h2, `DMA_BUSY_ADDR, 8'h00);
    check(rd, 8'h0A);
    @(posedge clk);
    xfer_active <= 7'h00;
    repeat (2) @(posedge clk);
    #1;
    check(channel_busy, 7'h00);
    check(chan_ready, 7'h00);
    $display("busy test done");
    @(posedge clk);
    ce <= 1'h0;
    acc(2'h1, `DMA_EN_ADDR, 8'h00);
    check(channel_enables, 7'h1F);
    @(posedge clk);
    ce <= 1'h1;
    $display("clock enable test done");
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    #1;
    check(channel_enables, 7'h00);
    $display("reset test done");
    tally_and_finish();
  end
endmodule : dma_channel_status_regs_tb
